// >>> tfe_pkg.sv
// constants shared by the translation and float exception unit
// assumes a 32-bit integer core and single-precision default results
// Contract
// - clean-page store: general vector, store-clean code
// - clean-page store records address and process id
// - return address, branch when in delay slot
// - exception entry shifts mode/enable stack, clears current
// - user miss without match raises refill
// - refill uses its own vector
// - refill code: fetch/load or store miss
// - refill records address, id, valid random index
// - context register addresses the page table word
// - random write fills entry at random index
// - probe places matching index in index register
// - indexed write fills entry at index register
// - per-type trap enable: trap or flag only
// - trap keeps state; otherwise substitute value written
// - five flag types; unimplemented always traps (code traps it only while fpIntEnable is high)
// - float exception sets flag, sticky, maybe interrupt
// - float trap: cause external interrupt, trap address
// - sticky held until software writes control word
// - defaults: quiet NaN, signed infinity
// - overflow default from rounding mode and sign
// - underflow never flagged; unimplemented instead
package tfe_pkg;
    localparam logic [31:0] GEN_VECTOR    = 32'h8000_0080;
    localparam logic [31:0] REFILL_VECTOR = 32'h8000_0000;
    localparam logic [4:0]  CODE_INT      = 5'h00;
    localparam logic [4:0]  CODE_CLEAN    = 5'h01;
    localparam logic [4:0]  CODE_FETCH    = 5'h02;
    localparam logic [4:0]  CODE_STORE    = 5'h03;
    // entry-low flag positions and instruction step
    localparam int LO_VALID = 9;
    localparam int LO_DIRTY = 10;
    localparam logic [31:0] INSTR_STEP    = 32'h0000_0004;
    // float flag positions: inexact, underflow, overflow, divzero, invalid, unimpl
    localparam int FL_I = 0;
    localparam int FL_U = 1;
    localparam int FL_O = 2;
    localparam int FL_Z = 3;
    localparam int FL_V = 4;
    localparam int FL_E = 5;
    // control word layout
    localparam int CSR_RM_LO   = 0;
    localparam int CSR_STK_LO  = 2;
    localparam int CSR_EN_LO   = 7;
    localparam int CSR_EXC_LO  = 12;
    // entry-high and context layout
    localparam int HI_PID_LO   = 6;
    localparam int HI_VPN_LO   = 12;
    localparam int CTX_BADV_LO = 2;
    localparam int CTX_BASE_LO = 21;
    localparam logic [5:0] RANDOM_RESET = 6'h3f;
    localparam logic [5:0] RANDOM_FLOOR = 6'h08;
    localparam logic [31:0] QNAN        = 32'h7fbf_ffff;
    localparam logic [31:0] POS_INF     = 32'h7f80_0000;
    localparam logic [31:0] MAX_FIN     = 32'h7f7f_ffff;
    localparam logic [1:0]  RM_NEAR     = 2'h0;
    localparam logic [1:0]  RM_ZERO     = 2'h1;
    localparam logic [1:0]  RM_PLUS     = 2'h2;
    localparam logic [1:0]  RM_MINUS    = 2'h3;
    localparam logic [31:0] CSR_ADDR    = 32'h0000_0000;
    localparam logic [31:0] RESP_ADDR   = 32'h0000_0004;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {TFE_NONE, TFE_FETCH, TFE_LOAD, TFE_STORE} tfe_access_type;
endpackage

// >>> tfe_unit.sv
// translation exception recording, translation buffer and float flags
// assumes core drives access requests and instruction strobes on core_clk
`timescale 1ns/1ps
module tfe_unit #(
    parameter int ENTRIES = 64
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire tfe_pkg::tfe_access_type accKind,
    input  wire logic [31:0]             accAddr,
    input  wire logic [31:0]             accPc,
    input  wire logic                    accInDelay,
    input  wire logic                    probeCmd,
    input  wire logic                    writeIndexCmd,
    input  wire logic                    writeRandomCmd,
    input  wire logic                    hiWrite,
    input  wire logic                    loWrite,
    input  wire logic                    indexWrite,
    input  wire logic                    ctxWrite,
    input  wire logic [31:0]             swData,
    input  wire logic                    fpDone,
    input  wire logic [5:0]              fpCond,
    input  wire logic                    fpSign,
    input  wire logic [31:0]             fpResult,
    input  wire logic [31:0]             fpPc,
    input  wire logic                    fpIntEnable,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             awaddr,
    input  wire logic                    wvalid,
    output logic                         wready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    output logic                         bvalid,
    input  wire logic                    bready,
    output logic [1:0]                   bresp,
    input  wire logic                    arvalid,
    output logic                         arready,
    input  wire logic [31:0]             araddr,
    output logic                         rvalid,
    input  wire logic                    rready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         excTake_r,
    output logic [31:0]                  excVector_r,
    output logic [4:0]                   exception_code_field_r,
    output logic                         delaySlotFlag_r,
    output logic [31:0]                  excPc_r,
    output logic [31:0]                  bad_virtual_address_r,
    output logic [31:0]                  context_r,
    output logic [31:0]                  transHigh_r,
    output logic [31:0]                  transLow_r,
    output logic [5:0]                   random_r,
    output logic [31:0]                  index_r,
    output logic [5:0]                   statusStack_r,
    output logic                         fpIrq_r,
    output logic                         fpWriteDest_r,
    output logic [31:0]                  fpDest_r
);
    import tfe_pkg::*;

    localparam int IW = $clog2(ENTRIES);

    // index and random fields are six bits wide
    if (ENTRIES != 64) begin : gBadEntries
        $error("tfe_unit serves 64 entries only");
    end

    logic [31:0] tagMem [ENTRIES];
    logic [31:0] dataMem [ENTRIES];
    logic        vpnHit  [ENTRIES];
    logic        hiHit   [ENTRIES];
    logic        hit;
    logic        hiAny;
    logic [IW-1:0] hitIdx;
    logic [IW-1:0] hiIdx;
    logic [31:0] csr_r;
    logic [31:0] csr_nxt;
    logic        trapTake;
    logic [5:0]  cond;
    logic [4:0]  enables;
    logic        missEv;
    logic        cleanEv;
    logic        invalidEv;
    logic        isUser;
    logic        awSeen_r;
    logic        wSeen_r;
    logic [31:0] wAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;

    // associative compare against access address and entry-high register
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : gCmp
            assign vpnHit[g] = (tagMem[g][31:HI_VPN_LO] == accAddr[31:HI_VPN_LO]) &&
                               (tagMem[g][HI_VPN_LO-1:HI_PID_LO] == transHigh_r[HI_VPN_LO-1:HI_PID_LO]);
            assign hiHit[g]  = (tagMem[g][31:HI_PID_LO] == transHigh_r[31:HI_PID_LO]);
        end
    endgenerate

    always_comb begin
        hit = 1'b0;
        hitIdx = '0;
        hiAny = 1'b0;
        hiIdx = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (vpnHit[i]) begin
                hit = 1'b1;
                hitIdx = IW'(i);
            end
            if (hiHit[i]) begin
                hiAny = 1'b1;
                hiIdx = IW'(i);
            end
        end
    end

    assign isUser    = (accKind != TFE_NONE) && !accAddr[31];
    assign missEv    = isUser && !hit;
    assign invalidEv = isUser && hit && !dataMem[hitIdx][LO_VALID];
    assign cleanEv   = isUser && hit && dataMem[hitIdx][LO_VALID] && !dataMem[hitIdx][LO_DIRTY] &&
                       (accKind == TFE_STORE);

    // translation exceptions
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            excTake_r <= 1'b0;
            excVector_r <= '0;
            exception_code_field_r <= '0;
            delaySlotFlag_r <= 1'b0;
            excPc_r <= '0;
            bad_virtual_address_r <= '0;
            statusStack_r <= '0;
        end else begin
            excTake_r <= missEv || invalidEv || cleanEv || trapTake;
            if (missEv || invalidEv || cleanEv) begin
                excVector_r <= missEv ? REFILL_VECTOR : GEN_VECTOR;
                exception_code_field_r <= cleanEv ? CODE_CLEAN :
                             (accKind == TFE_STORE) ? CODE_STORE : CODE_FETCH;
                excPc_r <= accInDelay ? accPc - INSTR_STEP : accPc;
                delaySlotFlag_r <= accInDelay;
                bad_virtual_address_r <= accAddr;
                statusStack_r <= {statusStack_r[3:0], 2'b00};
            end else if (trapTake) begin
                excVector_r <= GEN_VECTOR;
                exception_code_field_r <= CODE_INT;
                excPc_r <= fpPc;
                delaySlotFlag_r <= 1'b0;
                statusStack_r <= {statusStack_r[3:0], 2'b00};
            end
        end
    end

    // context, entry registers, index, random
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            context_r <= '0;
            transHigh_r <= '0;
            transLow_r <= '0;
            index_r <= '0;
            random_r <= RANDOM_RESET;
        end else begin
            random_r <= (random_r == RANDOM_FLOOR) ? RANDOM_RESET : random_r - 6'h01;
            if (missEv || invalidEv || cleanEv) begin
                context_r <= {context_r[31:CTX_BASE_LO], accAddr[30:HI_VPN_LO], 2'b00};
                transHigh_r <= {accAddr[31:HI_VPN_LO], transHigh_r[HI_VPN_LO-1:0]};
            end else begin
                if (ctxWrite) context_r <= {swData[31:CTX_BASE_LO], context_r[CTX_BASE_LO-1:0]};
                if (hiWrite) transHigh_r <= swData;
                if (loWrite) transLow_r <= swData;
            end
            if (probeCmd) index_r <= {!hiAny, {(31 - IW){1'b0}}, hiIdx};
            else if (indexWrite) index_r <= swData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (writeRandomCmd) begin
            tagMem[random_r] <= transHigh_r;
            dataMem[random_r] <= transLow_r;
        end else if (writeIndexCmd) begin
            tagMem[index_r[IW-1:0]] <= transHigh_r;
            dataMem[index_r[IW-1:0]] <= transLow_r;
        end
    end

    // float flags: underflow folds into unimplemented
    always_comb begin
        cond = fpCond;
        if (fpCond[FL_U]) cond[FL_E] = 1'b1;
        cond[FL_U] = 1'b0;
        if (fpCond[FL_O]) cond[FL_I] = 1'b1;
        enables = csr_r[CSR_EN_LO +: 5];
    end

    assign trapTake = fpDone && fpIntEnable &&
                      (cond[FL_E] || |(cond[4:0] & enables));

    always_comb begin
        csr_nxt = csr_r;
        if (awSeen_r && wSeen_r && wAddr_r == CSR_ADDR) begin
            for (int b = 0; b < 4; b++) begin
                if (wStrb_r[b]) csr_nxt[b*8 +: 8] = wData_r[b*8 +: 8];
            end
        end
        if (fpDone) begin
            csr_nxt[CSR_EXC_LO +: 6] = cond;
            csr_nxt[CSR_STK_LO +: 5] = csr_nxt[CSR_STK_LO +: 5] | cond[4:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            csr_r <= '0;
            fpIrq_r <= 1'b0;
            fpWriteDest_r <= 1'b0;
            fpDest_r <= '0;
        end else begin
            csr_r <= csr_nxt;
            fpIrq_r <= fpIntEnable && (csr_nxt[CSR_EXC_LO + FL_E] ||
                       |(csr_nxt[CSR_EXC_LO +: 5] & csr_nxt[CSR_EN_LO +: 5]));
            fpWriteDest_r <= fpDone && !trapTake;
            if (fpDone && !trapTake) begin
                if (cond[FL_V]) fpDest_r <= QNAN;
                else if (cond[FL_Z]) fpDest_r <= {fpSign, POS_INF[30:0]};
                else if (cond[FL_O]) begin
                    case (csr_r[CSR_RM_LO +: 2])
                        RM_NEAR:  fpDest_r <= {fpSign, POS_INF[30:0]};
                        RM_ZERO:  fpDest_r <= {fpSign, MAX_FIN[30:0]};
                        RM_PLUS:  fpDest_r <= fpSign ? {1'b1, MAX_FIN[30:0]} : POS_INF;
                        RM_MINUS: fpDest_r <= fpSign ? {1'b1, POS_INF[30:0]} : MAX_FIN;
                        default:  fpDest_r <= POS_INF;
                    endcase
                end else fpDest_r <= fpResult;
            end
        end
    end

    // register bus slave: control word at CSR_ADDR
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            awSeen_r <= 1'b0;
            wSeen_r <= 1'b0;
            wAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            awready <= !awSeen_r && !awready && awvalid && !bvalid;
            wready <= !wSeen_r && !wready && wvalid && !bvalid;
            if (awvalid && awready) begin
                awSeen_r <= 1'b1;
                wAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wSeen_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (awSeen_r && wSeen_r) begin
                awSeen_r <= 1'b0;
                wSeen_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wAddr_r == CSR_ADDR) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            arready <= !arready && arvalid && !rvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= (araddr == CSR_ADDR || araddr == RESP_ADDR) ? RESP_OKAY : RESP_SLVERR;
                rdata <= (araddr == CSR_ADDR) ? csr_r :
                         (araddr == RESP_ADDR) ? {26'h0, random_r} : '0;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    refill_vector_a: assert property (@(posedge core_clk) disable iff (reset)
        missEv |=> excTake_r && excVector_r == REFILL_VECTOR) else $error("refill vector wrong");
    clean_code_a: assert property (@(posedge core_clk) disable iff (reset)
        cleanEv |=> exception_code_field_r == CODE_CLEAN && excVector_r == GEN_VECTOR) else $error("clean code wrong");
    delay_pc_a: assert property (@(posedge core_clk) disable iff (reset)
        (missEv && accInDelay) |=> delaySlotFlag_r && excPc_r == $past(accPc) - INSTR_STEP)
        else $error("delay slot pc wrong");
    stack_shift_a: assert property (@(posedge core_clk) disable iff (reset)
        (missEv || cleanEv) |=> statusStack_r[1:0] == 2'b00 && statusStack_r[5:2] == $past(statusStack_r[3:0]))
        else $error("stack not shifted");
    bad_addr_a: assert property (@(posedge core_clk) disable iff (reset)
        (missEv || cleanEv) |=> bad_virtual_address_r == $past(accAddr)) else $error("address not captured");
    miss_code_a: assert property (@(posedge core_clk) disable iff (reset)
        (missEv && accKind == TFE_STORE) |=> exception_code_field_r == CODE_STORE) else $error("store miss code");
    random_range_a: assert property (@(posedge core_clk) disable iff (reset)
        random_r >= RANDOM_FLOOR) else $error("random out of range");
    no_under_a: assert property (@(posedge core_clk) disable iff (reset)
        (fpDone && !(awSeen_r && wSeen_r)) |=> !csr_r[CSR_EXC_LO + FL_U] &&
        csr_r[CSR_STK_LO + FL_U] == $past(csr_r[CSR_STK_LO + FL_U])) else $error("underflow flag set");
    fp_trap_a: assert property (@(posedge core_clk) disable iff (reset)
        (trapTake && !missEv && !cleanEv && !invalidEv) |=> exception_code_field_r == CODE_INT && excPc_r == $past(fpPc))
        else $error("float trap cause wrong");
    div_default_a: assert property (@(posedge core_clk) disable iff (reset)
        (fpDone && !trapTake && cond[FL_Z] && !cond[FL_V]) |=> fpWriteDest_r && fpDest_r[31] == $past(fpSign)
        && fpDest_r[30:0] == POS_INF[30:0]) else $error("divide default wrong");
endmodule

// >>> tfe_core_model.sv
// partner model of the integer pipeline and float unit
// assumes the bench calls its tasks; outputs change just after core_clk rises
`timescale 1ns/1ps
module tfe_core_model (
    input  wire logic               core_clk,
    output tfe_pkg::tfe_access_type accKind,
    output logic [31:0]             accAddr,
    output logic [31:0]             accPc,
    output logic                    accInDelay,
    output logic [6:0]              strobes,
    output logic [31:0]             swData,
    output logic                    fpDone,
    output logic [5:0]              fpCond,
    output logic                    fpSign,
    output logic [31:0]             fpResult,
    output logic [31:0]             fpPc
);
    import tfe_pkg::*;
    initial begin
        accKind = TFE_NONE;
        {accAddr, accPc, accInDelay, strobes, swData, fpDone, fpCond, fpSign, fpResult, fpPc} = '0;
    end
    // released address, pc and data lines show the inverse, not the old value
    task automatic access(input tfe_access_type k, input logic [31:0] a, input logic [31:0] pc, input logic d);
        @(posedge core_clk);
        accKind <= k;
        accAddr <= a;
        accPc <= pc;
        accInDelay <= d;
        @(posedge core_clk);
        accKind <= TFE_NONE;
        accAddr <= ~a;
        accPc <= ~pc;
    endtask
    task automatic pulse(input int which, input logic [31:0] d);
        @(posedge core_clk);
        strobes <= 7'h01 << which;
        swData <= d;
        @(posedge core_clk);
        strobes <= 7'h00;
        swData <= ~d;
    endtask
    task automatic fp(input logic [5:0] c, input logic s);
        @(posedge core_clk);
        fpDone <= 1'b1;
        fpCond <= c;
        fpSign <= s;
        fpResult <= 32'h3f80_0000;
        fpPc <= 32'h0000_2000;
        @(posedge core_clk);
        fpDone <= 1'b0;
        fpCond <= 6'h00;
    endtask
endmodule

// >>> tb.sv
// self-checking bench: translation exceptions, buffer commands, float flags
// assumes tfe_core_model plays core and float unit; control word over AXI4-Lite
`timescale 1ns/1ps
module tb;
    import tfe_pkg::*;
    logic           core_clk, reset, fpIntEnable, accInDelay, fpDone, fpSign, wrote;
    logic           awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic           excTake_r, delaySlotFlag_r, fpIrq_r, fpWriteDest_r;
    logic [1:0]     bresp, rresp, rsp;
    logic [3:0]     wstrb;
    logic [4:0]     exception_code_field_r;
    logic [5:0]     random_r, statusStack_r, fpCond;
    logic [6:0]     strobes;
    logic [31:0]    awaddr, wdata, araddr, rdata, excVector_r, excPc_r, bad_virtual_address_r, context_r, rd, big;
    logic [31:0]    transHigh_r, transLow_r, index_r, fpDest_r, accAddr, accPc, swData, fpResult, fpPc;
    tfe_access_type accKind;
    int             failCount, samplesChecked;

    tfe_core_model i_tfe_core_model (.*);
    tfe_unit i_tfe_unit (.*, .probeCmd(strobes[0]), .writeIndexCmd(strobes[1]), .writeRandomCmd(strobes[2]),
        .hiWrite(strobes[3]), .loWrite(strobes[4]), .indexWrite(strobes[5]), .ctxWrite(strobes[6]));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrapUp();
        $display("comparisons %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one write or one read; each channel released at its own handshake
    task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aDone;
        logic wDone;
        aDone = 1'b0;
        wDone = !wr;
        @(posedge core_clk);
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        wstrb <= s;
        for (int n = 0; n < 60; n++) begin
            @(posedge core_clk);
            if (!aDone && (wr ? awready : arready)) begin
                aDone = 1'b1;
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
            if (aDone && wDone && (wr ? bvalid : rvalid)) begin
                rsp = wr ? bresp : rresp;
                rd = rdata;
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        failCount++;
        wrapUp();
    endtask

    task automatic putEntry(input logic [31:0] hi, input logic [31:0] lo, input logic [31:0] idx);
        i_tfe_core_model.pulse(3, hi);
        i_tfe_core_model.pulse(4, lo);
        i_tfe_core_model.pulse(5, idx);
        i_tfe_core_model.pulse(1, 32'h0);
    endtask

    task automatic probe(input logic [31:0] hi);
        i_tfe_core_model.pulse(3, hi);
        i_tfe_core_model.pulse(0, 32'h0);
        repeat (3) @(posedge core_clk);
    endtask

    task automatic excCheck(input tfe_access_type k, input logic [31:0] a, input logic dly, input logic take,
                            input logic [31:0] vec, input logic [4:0] code);
        logic seen;
        seen = 1'b0;
        i_tfe_core_model.access(k, a, 32'h0000_1000, dly);
        for (int n = 0; n < 4; n++) begin
            @(posedge core_clk);
            seen = seen | excTake_r;
        end
        check(seen, take);
        if (take) begin
            check(excVector_r, vec);
            check(exception_code_field_r, code);
            check(excPc_r, dly ? 32'h0000_0ffc : 32'h0000_1000);
            check(delaySlotFlag_r, dly);
            check(bad_virtual_address_r, a);
            check(transHigh_r[31:6], {a[31:12], 6'h15});
            check(context_r, {11'h7ff, a[30:12], 2'h0});
            check(statusStack_r, 6'h00);
            check(random_r >= RANDOM_FLOOR, 1'b1);
        end
    endtask

    task automatic fpRun(input logic [5:0] c, input logic s);
        wrote = 1'b0;
        i_tfe_core_model.fp(c, s);
        for (int n = 0; n < 4; n++) begin
            @(posedge core_clk);
            wrote = wrote | fpWriteDest_r;
        end
    endtask

    initial begin
        reset = 1'b1;
        fpIntEnable = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr, wstrb} = '0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        check(random_r, 6'h3f);
        i_tfe_core_model.pulse(6, 32'hffe0_0000);
        i_tfe_core_model.pulse(3, 32'h0000_0540);
        excCheck(TFE_LOAD, 32'h0040_2abc, 1'b0, 1'b1, REFILL_VECTOR, CODE_FETCH);
        excCheck(TFE_FETCH, 32'h0001_1000, 1'b0, 1'b1, REFILL_VECTOR, CODE_FETCH);
        excCheck(TFE_STORE, 32'h7fff_f004, 1'b1, 1'b1, REFILL_VECTOR, CODE_STORE);
        axi(1'b0, RESP_ADDR, 32'h0, 4'h0);
        check(rd[5:0] >= RANDOM_FLOOR, 1'b1);
        $display("test refill done");
        putEntry(32'h0040_2540, 32'h0001_2200, 32'h5);
        check(transLow_r, 32'h0001_2200);
        probe(32'h0040_2540);
        check(index_r, 32'h0000_0005);
        excCheck(TFE_STORE, 32'h0040_2010, 1'b0, 1'b1, GEN_VECTOR, CODE_CLEAN);
        excCheck(TFE_LOAD, 32'h0040_2010, 1'b0, 1'b0, GEN_VECTOR, CODE_CLEAN);
        putEntry(32'h0050_3540, 32'h0, 32'h6);
        excCheck(TFE_LOAD, 32'h0050_3000, 1'b0, 1'b1, GEN_VECTOR, CODE_FETCH);
        i_tfe_core_model.pulse(4, 32'h0001_2600);
        i_tfe_core_model.pulse(3, 32'h0060_4540);
        i_tfe_core_model.pulse(2, 32'h0);
        probe(32'h0060_4540);
        check({index_r[31], index_r[5:0] >= RANDOM_FLOOR}, 2'b01);
        excCheck(TFE_STORE, 32'h0060_4ffc, 1'b0, 1'b0, GEN_VECTOR, CODE_CLEAN);
        probe(32'h0070_0540);
        check(index_r[31], 1'b1);
        $display("test buffer done");
        axi(1'b1, CSR_ADDR, 32'h0, 4'hf);
        fpRun(6'h08, 1'b1);
        check({wrote, fpIrq_r}, 2'b10);
        check(fpDest_r, 32'hff80_0000);
        fpRun(6'h10, 1'b0);
        check(fpDest_r, QNAN);
        axi(1'b0, CSR_ADDR, 32'h0, 4'h0);
        check(rd[6:2], 5'h18);
        check(rd[16], 1'b1);
        for (int m = 0; m < 8; m++) begin
            axi(1'b1, CSR_ADDR, m >> 1, 4'hf);
            big = (m[2:1] == RM_NEAR || (m[2:1] == RM_PLUS && !m[0]) || (m[2:1] == RM_MINUS && m[0]))
                ? POS_INF : MAX_FIN;
            fpRun(6'h04, m[0]);
            check(fpDest_r, {m[0], big[30:0]});
        end
        fpRun(6'h02, 1'b0);
        axi(1'b0, CSR_ADDR, 32'h0, 4'h0);
        check({rd[13], rd[3], rd[17]}, 3'b001);
        check(fpIrq_r, 1'b1);
        axi(1'b1, CSR_ADDR, 32'h0000_0400, 4'hf);
        fpRun(6'h08, 1'b0);
        check({wrote, fpIrq_r}, 2'b01);
        check(exception_code_field_r, CODE_INT);
        check(excPc_r, 32'h0000_2000);
        repeat (20) @(posedge core_clk);
        check(fpIrq_r, 1'b1);
        axi(1'b1, CSR_ADDR, 32'h0000_0454, 4'hf);
        repeat (2) @(posedge core_clk);
        check(fpIrq_r, 1'b0);
        axi(1'b1, CSR_ADDR, 32'h0000_ff03, 4'h1);
        check(rsp, RESP_OKAY);
        axi(1'b0, CSR_ADDR, 32'h0, 4'h0);
        check(rd & 32'h0003_ffff, 32'h0000_0403);
        fpIntEnable <= 1'b0;
        fpRun(6'h20, 1'b0);
        check(fpIrq_r, 1'b0);
        check(wrote, 1'b1);
        check(fpDest_r, 32'h3f80_0000);
        axi(1'b0, 32'h0000_0010, 32'h0, 4'h0);
        check(rsp, RESP_SLVERR);
        check(rd, 32'h0);
        $display("test float done");
        wrapUp();
    end
endmodule
